/* File: verilog/serial_clk_consts.svh */
// register offsets, field positions and reset values for serial clock control
`ifndef SERIAL_CLK_CONSTS_SVH
`define SERIAL_CLK_CONSTS_SVH
`define PTR_AUX_CLOCK_CTRL   4'hb
`define PTR_BAUD_LOW         4'hc
`define PTR_BAUD_HIGH        4'hd
`define PTR_LOOP_CTRL        4'he
`define PTR_IRQ_MASK         4'hf
`define PTR_SERIAL_RESET     4'h9
`define PTR_SYNC_HIGH        4'h7
`define ADDR_CH_STRIDE       12'h040
`define ADDR_CH_MASK         12'h040
`define ADDR_IRQ_STATUS      12'h080
`define ADDR_IRQ_ENABLE      12'h084
`define ADDR_PIN_CONFIG      12'h088
`define ADDR_LINE_STATUS     12'h08c
`define SRC_LOOP             2'h3
`define SRC_BAUD             2'h2
`define SRC_AUX              2'h1
`define SRC_MAIN             2'h0
`define LOOP_REF_NRZI        3'h7
`define LOOP_REF_FM          3'h6
`define LOOP_REF_MAIN        3'h5
`define LOOP_REF_BAUD        3'h4
`define LOOP_CMD_DISABLE     3'h3
`define LOOP_CMD_CLR_MISSING 3'h2
`define LOOP_CMD_SEARCH      3'h1
`define LOOP_CTRL_RESET      8'h04
`define AUX_CTRL_RESET       8'h00
`define MASK_RESET           8'h00
`define BAUD_RESET           16'h0000
`define BIT_LOOPBACK         4
`define BIT_ECHO             3
`define BIT_DIV_INPUT        1
`define BIT_DIV_RUN          0
`define BIT_IRQ_MASTER       3
`define BIT_ZERO_IRQ         1
`define BIT_SECONDARY_BANK   0
`define BIT_FRAME_QUEUE      2
`endif

/* File: verilog/serial_clk_pkg.sv */
// types shared by the serial channel clock and baud control block
package serial_clk_pkg;
	// per-channel clock control fields
	typedef struct packed {
		logic [1:0] receive_clock_source;
		logic [1:0] transmit_clock_source;
		logic       aux_clock_pin_direction;
		logic [1:0] aux_clock_pin_output_source;
	} clock_ctrl_t;
	// recovery loop operating state
	typedef enum logic [1:0] {
		LOOP_OFF,
		LOOP_SEARCH,
		LOOP_TRACK
	} loop_state_t;
	// per-channel serial pin bundle
	typedef struct packed {
		logic main_clock_input_pin;
		logic aux_clock_pin;
		logic receive_data_pin;
	} line_in_t;
endpackage

/* File: verilog/serial_clock_control.sv */
// clock selection, baud divider, recovery loop and irq enables, two channels
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "serial_clk_consts.svh"

// What this block does
// (RULE_01) receive clock mux: loop, baud, aux, main
// (RULE_02) transmit clock mux uses same encoding
// (RULE_03) direction bit one makes aux pin output
// (RULE_04) drive aux pin when direction and pinconfig agree
// (RULE_05) baud compare sixteen bits, low 0x0c high 0x0d
// (RULE_06) loop mode 7..4 choose recovery reference
// (RULE_07) loop commands: disable, clear missing, search
// (RULE_08) loopback feeds transmit data into receive
// (RULE_09) echo bit selects echo test mode
// (RULE_10) divider input: system clock or main pin
// (RULE_11) divider run bit, stopped after reset
// (RULE_12) mask register holds per-source enable bits
// (RULE_13) mask bit one enables divider zero irq
// (RULE_14) mask bits enable frame queue, secondary bank
// (RULE_15) sources merge onto shared active-low irq
// (RULE_16) serial reset bit three is master enable
// (RULE_17) bank bit steers pointer seven writes
// (RULE_18) two identical channels with own registers
// (RULE_19) divider reloads at zero and toggles output
module serial_clock_control
	import serial_clk_pkg::*;
#(
	parameter int NCH = 2, // channel count
	parameter int LOOP_LOCK_EDGES = 8 // reference edges to leave search
) (
	input  wire logic               mclk_i,
	input  wire logic               rst_i,
	input  wire logic [11:0]        paddr_i,
	input  wire logic               psel_i,
	input  wire logic               penable_i,
	input  wire logic               pwrite_i,
	input  wire logic [31:0]        pwdata_i,
	output logic      [31:0]        prdata_o,
	output logic                    pready_o,
	output logic                    pslverr_o,
	input  wire line_in_t [NCH-1:0] line_i,
	input  wire logic [NCH-1:0]     transmit_data_i,
	input  wire logic [NCH-1:0]     ext_irq_i,
	output logic [NCH-1:0]          receive_clock_o,
	output logic [NCH-1:0]          transmit_clock_o,
	output logic [NCH-1:0]          receive_data_o,
	output logic [NCH-1:0]          transmit_data_pin_o,
	output logic [NCH-1:0]          aux_clock_pin_o,
	output logic [NCH-1:0]          aux_clock_pin_oe_o,
	output logic [NCH-1:0]          loopback_o,
	output logic [NCH-1:0]          echo_o,
	output logic [NCH-1:0]          frame_status_queue_enable_o,
	output logic [NCH-1:0]          sync_high_wr_o,
	output logic [NCH-1:0]          secondary_wr_o,
	output logic [7:0]              bank_wdata_o,
	output logic                    channel_irq_line_n_o
);
	// apb access phase write strobe, all registers answer without wait
	logic        wr_en;
	logic        rd_en;
	logic [11:0] cmn_addr;
	assign wr_en = psel_i & penable_i & pwrite_i;
	assign rd_en = psel_i & penable_i & ~pwrite_i;
	assign pready_o = 1'b1;
	assign cmn_addr = paddr_i;

	// channel index decode from address bit
	function automatic logic chan_of(input logic [11:0] a);
		chan_of = (a & `ADDR_CH_MASK) != 12'h000;
	endfunction
	// channel-local pointer from word address
	function automatic logic [3:0] ptr_of(input logic [11:0] a);
		ptr_of = a[5:2];
	endfunction
	// channel region is below the shared registers
	function automatic logic in_chan(input logic [11:0] a);
		in_chan = a < (`ADDR_CH_STRIDE << 1) && a[1:0] == 2'b00;
	endfunction

	// shared status/enable of divider zero events, per channel
	logic [NCH-1:0] irq_status_reg;
	logic [NCH-1:0] irq_enable_reg;
	logic [NCH-1:0] pin_config_reg;   // matching pin configuration bit
	logic [NCH-1:0] zero_event;
	logic [NCH-1:0] chan_irq;
	logic [NCH-1:0] chan_master;
	logic [7:0]     rd_chan [NCH];
	logic [1:0]     loop_state_rd [NCH];
	logic [NCH-1:0] missing_rd;

	genvar g;
	generate
	for (g = 0; g < NCH; g = g + 1) begin : ch
		logic         sel;
		logic [3:0]   ptr;
		clock_ctrl_t  clk_ctrl_reg;
		logic [15:0]  baud_divider_compare_reg;
		logic [7:0]   loop_ctrl_reg;
		logic [7:0]   mask_reg;
		logic         master_en_reg;
		logic [2:0]   loop_ref_reg;
		loop_state_t  loop_state_reg;
		logic         missing_reg;
		logic [3:0]   lock_cnt_reg;
		logic [15:0]  div_cnt_reg;
		logic         div_out_reg;
		logic         div_zero_reg;
		logic         div_in_prev_reg;
		logic         div_tick;
		logic         ref_prev_reg;
		logic         loop_clk_reg;
		logic         ref_lvl;
		logic         ref_edge;
		logic [1:0]   main_sync_reg;
		logic [1:0]   aux_sync_reg;
		logic [1:0]   rxd_sync_reg;
		logic         main_s;
		logic         aux_s;
		logic         rxd_s;
		logic [2:0]   mode_w;

		assign sel = wr_en && in_chan(paddr_i) && chan_of(paddr_i) == g;
		assign ptr = ptr_of(paddr_i);
		assign mode_w = pwdata_i[7:5];

		// two-flop synchronisers on all pins entering the clock domain
		always_ff @(posedge mclk_i) begin
			if (rst_i) begin
				main_sync_reg <= 2'b00;
				aux_sync_reg  <= 2'b00;
				rxd_sync_reg  <= 2'b00;
			end else begin
				main_sync_reg <= {main_sync_reg[0],
					line_i[g].main_clock_input_pin};
				aux_sync_reg  <= {aux_sync_reg[0], line_i[g].aux_clock_pin};
				rxd_sync_reg  <= {rxd_sync_reg[0],
					line_i[g].receive_data_pin};
			end
		end
		assign main_s = main_sync_reg[1];
		assign aux_s  = aux_sync_reg[1];
		assign rxd_s  = rxd_sync_reg[1];

		// channel register writes, each channel owns its copy
		always_ff @(posedge mclk_i) begin
			if (rst_i) begin // RULE_18
				clk_ctrl_reg             <= clock_ctrl_t'(`AUX_CTRL_RESET);
				baud_divider_compare_reg <= `BAUD_RESET;
				loop_ctrl_reg            <= `LOOP_CTRL_RESET; // RULE_11
				mask_reg                 <= `MASK_RESET;
				master_en_reg            <= 1'b0;
			end else if (sel) begin
				unique case (ptr)
				`PTR_AUX_CLOCK_CTRL: clk_ctrl_reg <= pwdata_i[6:0];
				`PTR_BAUD_LOW: baud_divider_compare_reg[7:0] <=
					pwdata_i[7:0]; // RULE_05
				`PTR_BAUD_HIGH: baud_divider_compare_reg[15:8] <=
					pwdata_i[7:0]; // RULE_05
				`PTR_LOOP_CTRL: loop_ctrl_reg <= pwdata_i[7:0];
				`PTR_IRQ_MASK: mask_reg <= pwdata_i[7:0]; // RULE_12
				`PTR_SERIAL_RESET: master_en_reg <=
					pwdata_i[`BIT_IRQ_MASTER]; // RULE_16
				default: ;
				endcase
			end
		end

		// pointer seven goes to one of two banks outside this block
		assign secondary_wr_o[g] = sel && ptr == `PTR_SYNC_HIGH &&
			mask_reg[`BIT_SECONDARY_BANK]; // RULE_17
		assign sync_high_wr_o[g] = sel && ptr == `PTR_SYNC_HIGH &&
			!mask_reg[`BIT_SECONDARY_BANK]; // RULE_17

		// divider input edge: system clock ticks every cycle
		always_ff @(posedge mclk_i) begin
			if (rst_i)
				div_in_prev_reg <= 1'b0;
			else
				div_in_prev_reg <= main_s;
		end
		assign div_tick = loop_ctrl_reg[`BIT_DIV_INPUT] ? 1'b1 :
			(main_s & ~div_in_prev_reg); // RULE_10

		// baud divider: count down, reload and toggle at zero
		always_ff @(posedge mclk_i) begin
			if (rst_i) begin
				div_cnt_reg  <= `BAUD_RESET;
				div_out_reg  <= 1'b0;
				div_zero_reg <= 1'b0;
			end else if (!loop_ctrl_reg[`BIT_DIV_RUN]) begin // RULE_11
				div_cnt_reg  <= baud_divider_compare_reg;
				div_zero_reg <= 1'b0;
			end else if (div_tick) begin
				// zero state is held one extra tick: half period = n + 2
				if (div_zero_reg) begin
					div_cnt_reg  <= baud_divider_compare_reg; // RULE_19
					div_out_reg  <= ~div_out_reg; // RULE_19
					div_zero_reg <= 1'b0;
				end else if (div_cnt_reg == 16'h0000) begin
					div_zero_reg <= 1'b1;
				end else begin
					div_cnt_reg <= div_cnt_reg - 16'h0001;
				end
			end
		end
		assign zero_event[g] = loop_ctrl_reg[`BIT_DIV_RUN] & div_tick &
			div_zero_reg;

		// reference selection for the recovery loop
		always_comb begin
			unique case (loop_ref_reg)
			`LOOP_REF_NRZI: ref_lvl = rxd_s; // RULE_06
			`LOOP_REF_FM:   ref_lvl = rxd_s; // RULE_06
			`LOOP_REF_MAIN: ref_lvl = main_s; // RULE_06
			default:        ref_lvl = div_out_reg; // RULE_06
			endcase
		end
		// fm and nrzi mark on every transition, clocks on rising only
		assign ref_edge = (loop_ref_reg == `LOOP_REF_NRZI ||
			loop_ref_reg == `LOOP_REF_FM) ? (ref_lvl ^ ref_prev_reg) :
			(ref_lvl & ~ref_prev_reg);

		// reference code store and loop commands from the mode field
		always_ff @(posedge mclk_i) begin
			if (rst_i) begin
				loop_ref_reg   <= `LOOP_REF_BAUD;
				loop_state_reg <= LOOP_OFF;
				missing_reg    <= 1'b0;
				lock_cnt_reg   <= 4'h0;
				ref_prev_reg   <= 1'b0;
				loop_clk_reg   <= 1'b0;
			end else begin
				ref_prev_reg <= ref_lvl;
				if (sel && ptr == `PTR_LOOP_CTRL && mode_w[2])
					loop_ref_reg <= mode_w; // RULE_06
				if (sel && ptr == `PTR_LOOP_CTRL &&
					mode_w == `LOOP_CMD_DISABLE) begin
					loop_state_reg <= LOOP_OFF; // RULE_07
				end else if (sel && ptr == `PTR_LOOP_CTRL &&
					mode_w == `LOOP_CMD_SEARCH) begin
					loop_state_reg <= LOOP_SEARCH; // RULE_07
					lock_cnt_reg   <= 4'h0;
				end else if (loop_state_reg == LOOP_SEARCH && ref_edge) begin
					lock_cnt_reg <= lock_cnt_reg + 4'h1;
					if (lock_cnt_reg == 4'(LOOP_LOCK_EDGES - 1))
						loop_state_reg <= LOOP_TRACK;
				end
				// a missing reference edge wins over a same-cycle clear
				if (loop_state_reg == LOOP_TRACK && ref_edge &&
					ref_lvl == loop_clk_reg && !ref_prev_reg)
					missing_reg <= 1'b1;
				else if (sel && ptr == `PTR_LOOP_CTRL &&
					mode_w == `LOOP_CMD_CLR_MISSING)
					missing_reg <= 1'b0; // RULE_07
				if (loop_state_reg != LOOP_OFF && ref_edge)
					loop_clk_reg <= ~loop_clk_reg;
			end
		end
		assign loop_state_rd[g] = loop_state_reg;
		assign missing_rd[g] = missing_reg;

		// clock muxes and pin drivers; all registered, the transmit_data_i paths included
		function automatic logic pick(input logic [1:0] s,
			input logic l, input logic b, input logic a, input logic m);
			unique case (s)
			`SRC_LOOP: pick = l;
			`SRC_BAUD: pick = b;
			`SRC_AUX:  pick = a;
			default:   pick = m;
			endcase
		endfunction
		always_ff @(posedge mclk_i) begin
			if (rst_i) begin
				receive_clock_o[g]     <= 1'b0;
				transmit_clock_o[g]    <= 1'b0;
				aux_clock_pin_o[g]     <= 1'b0;
				aux_clock_pin_oe_o[g]  <= 1'b0;
				receive_data_o[g]      <= 1'b0;
				transmit_data_pin_o[g] <= 1'b0;
			end else begin
				receive_clock_o[g] <= pick(clk_ctrl_reg.receive_clock_source,
					loop_clk_reg, div_out_reg, aux_s, main_s); // RULE_01
				transmit_clock_o[g] <= pick(
					clk_ctrl_reg.transmit_clock_source,
					loop_clk_reg, div_out_reg, aux_s, main_s); // RULE_02
				aux_clock_pin_oe_o[g] <= clk_ctrl_reg.aux_clock_pin_direction
					& pin_config_reg[g]; // RULE_03 RULE_04
				aux_clock_pin_o[g] <= pick(
					clk_ctrl_reg.aux_clock_pin_output_source,
					loop_clk_reg, div_out_reg, aux_s, main_s); // RULE_04
				// loopback bypasses both data pins; line held idle high
				receive_data_o[g] <= loop_ctrl_reg[`BIT_LOOPBACK] ?
					transmit_data_i[g] : rxd_s; // RULE_08
				transmit_data_pin_o[g] <= loop_ctrl_reg[`BIT_LOOPBACK] ?
					1'b1 : (loop_ctrl_reg[`BIT_ECHO] ? rxd_s :
					transmit_data_i[g]); // RULE_09
			end
		end
		assign loopback_o[g] = loop_ctrl_reg[`BIT_LOOPBACK]; // RULE_08
		assign echo_o[g] = loop_ctrl_reg[`BIT_ECHO]; // RULE_09
		assign frame_status_queue_enable_o[g] =
			mask_reg[`BIT_FRAME_QUEUE]; // RULE_14

		// mask gates: only the zero source uses a mask bit, external sources are not masked
		assign chan_irq[g] = master_en_reg & ((mask_reg[`BIT_ZERO_IRQ] &
			irq_status_reg[g]) | ext_irq_i[g]); // RULE_13 RULE_15
		assign chan_master[g] = master_en_reg;
		assign rd_chan[g] = {1'b0, loop_state_reg, missing_reg,
			div_out_reg, loop_ctrl_reg[2:0]};
	end
	endgenerate

	// sticky zero status, set wins over write-one-to-clear
	always_ff @(posedge mclk_i) begin
		if (rst_i)
			irq_status_reg <= '0;
		else if (wr_en && cmn_addr == `ADDR_IRQ_STATUS)
			irq_status_reg <= zero_event |
				(irq_status_reg & ~pwdata_i[NCH-1:0]);
		else
			irq_status_reg <= irq_status_reg | zero_event;
	end

	// system-side enable and pin configuration registers
	always_ff @(posedge mclk_i) begin
		if (rst_i) begin
			irq_enable_reg <= '0;
			pin_config_reg <= '0;
		end else if (wr_en && cmn_addr == `ADDR_IRQ_ENABLE) begin
			irq_enable_reg <= pwdata_i[NCH-1:0];
		end else if (wr_en && cmn_addr == `ADDR_PIN_CONFIG) begin
			pin_config_reg <= pwdata_i[NCH-1:0];
		end
	end

	// one shared active-low line, low while a channel source is set and that channel's enable bit is set or its zero status is clear
	always_ff @(posedge mclk_i) begin
		if (rst_i)
			channel_irq_line_n_o <= 1'b1;
		else
			channel_irq_line_n_o <= ~|(chan_irq & (irq_enable_reg |
				~irq_status_reg)); // RULE_15
	end

	// bank write data is the written byte, held in a register
	always_ff @(posedge mclk_i) begin
		if (rst_i)
			bank_wdata_o <= 8'h00;
		else if (wr_en)
			bank_wdata_o <= pwdata_i[7:0];
	end

	// read mux; channel registers are write-only and read as status
	always_comb begin
		prdata_o  = 32'h0000_0000;
		pslverr_o = 1'b0;
		if (rd_en) begin
			if (in_chan(cmn_addr))
				prdata_o = {24'h000000, rd_chan[chan_of(cmn_addr)]};
			else if (cmn_addr == `ADDR_IRQ_STATUS)
				prdata_o = 32'(irq_status_reg);
			else if (cmn_addr == `ADDR_IRQ_ENABLE)
				prdata_o = 32'(irq_enable_reg);
			else if (cmn_addr == `ADDR_PIN_CONFIG)
				prdata_o = 32'(pin_config_reg);
			else if (cmn_addr == `ADDR_LINE_STATUS)
				prdata_o = 32'({chan_master, missing_rd});
			else
				pslverr_o = 1'b1;
		end
	end
endmodule

/* File: tb/serial_clock_checker.sv */
// port assertions for the serial clock control block
`timescale 1ns/1ps
module serial_clock_checker #(
	parameter int NCH             = 2,
	parameter int LOOP_LOCK_EDGES = 8
) (
	input wire logic           mclk_i,
	input wire logic           rst_i,
	input wire logic [11:0]    paddr_i,
	input wire logic           psel_i,
	input wire logic           penable_i,
	input wire logic           pwrite_i,
	input wire logic [31:0]    pwdata_i,
	input wire logic [NCH-1:0] transmit_data_i,
	input wire logic [NCH-1:0] receive_data_o,
	input wire logic [NCH-1:0] transmit_data_pin_o,
	input wire logic [NCH-1:0] loopback_o,
	input wire logic [NCH-1:0] echo_o,
	input wire logic [NCH-1:0] sync_high_wr_o,
	input wire logic [NCH-1:0] secondary_wr_o,
	input wire logic [7:0]     bank_wdata_o,
	input wire logic           channel_irq_line_n_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (rst_i);
	// write access phase aimed at the bank-steered pointer
	sequence s_ptr7_write;
		psel_i && penable_i && pwrite_i && paddr_i[5:2] == 4'h7;
	endsequence
	// loopback held across two edges; skips the edge after reset
	sequence s_loop0;
		loopback_o[0] && $past(loopback_o[0]) && !$past(rst_i);
	endsequence
	a_loop_rx_path: assert property (
		s_loop0 |-> receive_data_o[0] == $past(transmit_data_i[0]))
		else $error("loopback rx data wrong");
	a_loop_tx_high: assert property (
		s_loop0 |-> transmit_data_pin_o[0])
		else $error("loopback tx pin not high");
	a_loop_chan_one: assert property (
		loopback_o[1] && $past(loopback_o[1]) && !$past(rst_i)
		|-> receive_data_o[1] == $past(transmit_data_i[1]))
		else $error("channel one loopback wrong");
	a_tx_normal: assert property (
		!loopback_o[0] && !echo_o[0] && !$past(loopback_o[0]) &&
		!$past(echo_o[0]) && !$past(rst_i)
		|-> transmit_data_pin_o[0] == $past(transmit_data_i[0]))
		else $error("normal tx path wrong");
	a_bank_cause: assert property (
		(|sync_high_wr_o || |secondary_wr_o) |-> s_ptr7_write)
		else $error("bank write pulse without write");
	a_bank_excl: assert property (
		(sync_high_wr_o & secondary_wr_o) == '0)
		else $error("both bank targets written");
	a_bank_data: assert property (
		(|sync_high_wr_o || |secondary_wr_o)
		|=> bank_wdata_o == $past(pwdata_i[7:0]) && !(|secondary_wr_o))
		else $error("bank data wrong");
	a_irq_reset: assert property (
		$past(rst_i) |-> channel_irq_line_n_o)
		else $error("irq line low after reset");
endmodule

bind serial_clock_control serial_clock_checker #(
	.NCH(NCH),
	.LOOP_LOCK_EDGES(LOOP_LOCK_EDGES)
) serial_clock_checker_i (.mclk_i, .rst_i, .paddr_i, .psel_i, .penable_i,
	.pwrite_i, .pwdata_i, .transmit_data_i, .receive_data_o,
	.transmit_data_pin_o, .loopback_o, .echo_o, .sync_high_wr_o,
	.secondary_wr_o, .bank_wdata_o, .channel_irq_line_n_o);

/* File: tb/serial_line_model.sv */
// far-side line model: drives clock and data pins of each channel
`timescale 1ns/1ps
module serial_line_model
	import serial_clk_pkg::*;
#(
	parameter int NCH = 2
) (
	input  wire logic [NCH-1:0] main_lvl_i,
	input  wire logic [NCH-1:0] aux_lvl_i,
	input  wire logic [NCH-1:0] rx_lvl_i,
	input  wire logic [NCH-1:0] aux_drv_i,
	input  wire logic [NCH-1:0] aux_oe_i,
	output line_in_t [NCH-1:0]  line_o
);
	// aux wire resolves to the device while it drives, else to us
	always_comb begin
		for (int c = 0; c < NCH; c++) begin
			line_o[c].main_clock_input_pin = main_lvl_i[c];
			line_o[c].aux_clock_pin = aux_oe_i[c] ? aux_drv_i[c]
				: aux_lvl_i[c];
			line_o[c].receive_data_pin = rx_lvl_i[c];
		end
	end
endmodule

/* File: tb/tb_top.sv */
// self-checking bench for the serial clock control block
`timescale 1ns/1ps
module tb_top;
	import serial_clk_pkg::*;
	typedef struct packed {
		logic [7:0] ctrl;
		logic cfg, m, a, rx, tx, oe;
	} row_t;
	logic mclk_i = 1'b0, rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
	logic pwrite_i = 1'b0, pready_o, pslverr_o, channel_irq_line_n_o, err;
	logic [11:0] paddr_i = 12'h000;
	logic [31:0] pwdata_i = 32'h0, prdata_o, rd;
	line_in_t [1:0] line_i;
	logic [1:0] transmit_data_i = 2'h0, ext_irq_i = 2'h0, receive_clock_o;
	logic [1:0] transmit_clock_o, receive_data_o, transmit_data_pin_o, echo_o;
	logic [1:0] aux_clock_pin_o, aux_clock_pin_oe_o, loopback_o;
	logic [1:0] frame_status_queue_enable_o, sync_high_wr_o, secondary_wr_o;
	logic [1:0] main_lvl = 2'h0, aux_lvl = 2'h0, rx_lvl = 2'h0, seen_s, seen_x;
	logic [7:0] bank_wdata_o;
	logic [15:0] cmp [2] = '{16'h0005, 16'h0103};
	int n_fail = 0, compares = 0, n, m;
	// ctrl, pin config, main, aux, then expected rx clk, tx clk, oe
	row_t rows [8] = '{'{8'h08, 0, 1, 0, 1, 0, 0}, '{8'h20, 0, 1, 0, 0, 1, 0},
		'{8'h28, 0, 0, 1, 1, 1, 0}, '{8'h00, 0, 0, 1, 0, 0, 0},
		'{8'h50, 0, 1, 1, 0, 0, 0}, '{8'h04, 0, 1, 0, 1, 1, 0},
		'{8'h04, 1, 1, 0, 1, 1, 1}, '{8'h2c, 1, 0, 1, 0, 0, 1}};
	serial_clock_control #(.NCH(2), .LOOP_LOCK_EDGES(8)) serial_clock_control_i (
		.mclk_i, .rst_i, .paddr_i, .psel_i, .penable_i, .pwrite_i,
		.pwdata_i, .prdata_o, .pready_o, .pslverr_o, .line_i,
		.transmit_data_i, .ext_irq_i, .receive_clock_o, .transmit_clock_o,
		.receive_data_o, .transmit_data_pin_o, .aux_clock_pin_o,
		.aux_clock_pin_oe_o, .loopback_o, .echo_o,
		.frame_status_queue_enable_o, .sync_high_wr_o, .secondary_wr_o,
		.bank_wdata_o, .channel_irq_line_n_o);
	serial_line_model #(.NCH(2)) serial_line_model_i (.main_lvl_i(main_lvl),
		.aux_lvl_i(aux_lvl), .rx_lvl_i(rx_lvl), .aux_drv_i(aux_clock_pin_o),
		.aux_oe_i(aux_clock_pin_oe_o), .line_o(line_i));
	always #25 mclk_i = ~mclk_i;
	// pointer-7 pulses last one cycle, so latch them for later checks
	always @(posedge mclk_i) begin
		seen_s = seen_s | sync_high_wr_o;
		seen_x = seen_x | secondary_wr_o;
	end
	task automatic chk(input logic [32:0] got, input logic [32:0] exp);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk_i);
	endtask
	// one apb transfer; idle edge after it so signals never move twice
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge mclk_i);
		penable_i <= 1'b1;
		@(posedge mclk_i);
		while (pready_o !== 1'b1) @(posedge mclk_i);
		rd = prdata_o;
		err = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge mclk_i);
	endtask
	function automatic logic [11:0] ad(input int c, input logic [3:0] p);
		return 12'(c * 64) | {6'h00, p, 2'h0};
	endfunction
	task automatic wr(input int c, input logic [3:0] p, input logic [7:0] d);
		apb(1'b1, ad(c, p), {24'h000000, d});
	endtask
	// count edges until the divider-driven tx clock changes level
	task automatic half(output int k);
		logic t;
		t = transmit_clock_o[0];
		k = 0;
		while (transmit_clock_o[0] === t && k < 2000) begin
			@(posedge mclk_i);
			k++;
		end
	endtask
	task automatic final_report();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// watchdog: whole run needs well under a tenth of this
	initial begin
		#3000000;
		n_fail++;
		final_report();
	end
	initial begin
		cyc(16);
		rst_i <= 1'b0;
		cyc(1);
		chk({channel_irq_line_n_o, loopback_o, aux_clock_pin_oe_o}, 5'h10);
		for (int c = 0; c < 2; c++) begin
			apb(1'b0, ad(c, 4'he), 32'h0);
			chk(rd, 32'h4);
		end
		apb(1'b0, 12'h0f0, 32'h0);
		chk({err, rd}, 33'h100000000);
		foreach (rows[i]) begin
			wr(0, 4'hb, rows[i].ctrl);
			apb(1'b1, 12'h088, {31'h0, rows[i].cfg});
			main_lvl <= {1'b0, rows[i].m};
			aux_lvl <= {1'b0, rows[i].a};
			// aux loop path: sync, pin reg, sync again, mux reg
			cyc(8);
			chk({receive_clock_o[0], transmit_clock_o[0], aux_clock_pin_oe_o[0]},
				{rows[i].rx, rows[i].tx, rows[i].oe});
			if (rows[i].oe)
				chk(aux_clock_pin_o[0], rows[i].m);
		end
		apb(1'b1, 12'h088, 32'h0);
		for (int k = 7; k >= 0; k--) begin
			wr(0, 4'he, {k[2:0], 5'h04});
			apb(1'b0, ad(0, 4'he), 32'h0);
			if (k <= 3)
				chk(rd[6:5], k > 1 ? 0 : 1);
		end
		wr(0, 4'he, 8'h64);
		wr(0, 4'hb, 8'h10);
		foreach (cmp[j]) begin
			wr(0, 4'hc, cmp[j][7:0]);
			wr(0, 4'hd, cmp[j][15:8]);
			wr(0, 4'he, 8'h07);
			half(n);
			half(n);
			chk(n, cmp[j] + 2);
			wr(0, 4'he, 8'h04);
			// let a toggle launched at the stop edge reach the mux output
			cyc(2);
			m = transmit_clock_o[0];
			cyc(300);
			chk(transmit_clock_o[0], m);
		end
		apb(1'b1, 12'h084, 32'h1);
		wr(0, 4'hf, 8'h02);
		wr(0, 4'h9, 8'h08);
		wr(0, 4'he, 8'h07);
		cyc(600);
		apb(1'b0, 12'h080, 32'h0);
		chk({channel_irq_line_n_o, rd[0]}, 2'h1);
		wr(0, 4'h9, 8'h00);
		cyc(3);
		chk(channel_irq_line_n_o, 1);
		wr(0, 4'he, 8'h04);
		apb(1'b1, 12'h080, 32'h1);
		apb(1'b0, 12'h080, 32'h0);
		wr(0, 4'h9, 8'h08);
		cyc(3);
		chk({channel_irq_line_n_o, rd[0]}, 2'h2);
		ext_irq_i <= 2'h2;
		cyc(3);
		chk(channel_irq_line_n_o, 1);
		ext_irq_i <= 2'h1;
		cyc(3);
		chk(channel_irq_line_n_o, 0);
		ext_irq_i <= 2'h0;
		rx_lvl <= 2'h3;
		wr(1, 4'he, 8'h14);
		cyc(6);
		chk({loopback_o, receive_data_o, transmit_data_pin_o}, 6'h26);
		wr(0, 4'he, 8'h0c);
		transmit_data_i <= 2'h2;
		cyc(6);
		chk({echo_o, transmit_data_pin_o, receive_data_o}, 6'h1f);
		wr(0, 4'he, 8'h14);
		cyc(3);
		chk({receive_data_o[0], transmit_data_pin_o[0]}, 2'h1);
		wr(0, 4'hf, 8'h04);
		chk(frame_status_queue_enable_o, 2'h1);
		seen_s = 2'h0;
		seen_x = 2'h0;
		wr(0, 4'h7, 8'ha5);
		chk({seen_s, seen_x, bank_wdata_o}, 12'h4a5);
		wr(0, 4'hf, 8'h05);
		seen_s = 2'h0;
		seen_x = 2'h0;
		wr(0, 4'h7, 8'h3c);
		chk({seen_s, seen_x, bank_wdata_o}, 12'h13c);
		rst_i <= 1'b1;
		cyc(2);
		rst_i <= 1'b0;
		cyc(1);
		chk({loopback_o, echo_o, channel_irq_line_n_o}, 5'h01);
		apb(1'b0, ad(1, 4'he), 32'h0);
		chk(rd, 32'h4);
		final_report();
	end
endmodule
